// file: core/i2c_slave_register_access.sv
// Purpose: Two-wire bus slave giving a host access to a register space.
// Assumes: SCL and SDA arrive asynchronously; the register file runs
//          on REG_CLK_I and answers a read one of its cycles later.
// Notes:   SCL is only ever sampled; the slave never holds it low.
`timescale 1ns/1ps

// Notes on behaviour
// - Never hold SCL low; no clock stretching.
// - Ignore the general call address.
// - Give no device identification response.
// - Slave only; no clock or arbitration.
// - High-speed entry code is not acknowledged.
// - Keep up with 400 kbit/s and 1 Mbit/s.
// - Glitch filter on both SCL and SDA.
// - SDA changes only while SCL is low.
// - Falling SDA with SCL high starts; bus busy.
// - Rising SDA with SCL high stops the frame.
// - Repeated start restarts the address phase.
// - Bytes MSB first, each followed by acknowledge.
// - Receiver pulls SDA low during acknowledge.
// - On master not-acknowledge, release SDA.
// - Match when upper five bits are 01010.
// - Low two address bits come from configuration.
// - FIFO address: pointer stays on every write.
// - Other addresses: pointer increments after each byte.
// - Reads return pointer data, then incremented addresses; at the FIFO address every read fetches the same address.
module i2c_slave_register_access #(
  parameter logic [7:0] FIFO_ADDR = i2c_slave_pkg::FIFO_ADDR_DEFAULT
) (
  input  wire logic       CLK_I,
  input  wire logic       ARST_N_I,
  input  wire logic       REG_CLK_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_N_O,
  input  wire logic [1:0] ADDR_LOW_I,
  output logic            BUSY_O,
  output logic [7:0]      REG_ADDR_O,
  output logic [7:0]      REG_WDATA_O,
  output logic            REG_WR_O,
  output logic            REG_RD_O,
  input  wire logic [7:0] REG_RDATA_I
);
  import i2c_slave_pkg::*;

  localparam int RD_FETCH_MAX = 100;

  state_type  state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic       oe_n_next, sda_o_next, busy_next;
  logic [1:0] al_s1_reg, al_s2_reg;
  logic       scl_f, sda_f, scl_d_reg, sda_d_reg;
  logic       scl_rise, scl_fall, start_evt, stop_evt;
  logic       byte_done, ack_end, addr_hit, rx_state;
  logic       addr_read_hit, load_tx, write_go, fetch_go;
  logic       nack_seen, rd_done;
  logic [7:0] rd_data, ptr_adv;

  // Both lines pass the spike filter; SCL has no driver here.
  pin_filter u_scl_filt (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .pin_i    (SCL_I),
    .level_o  (scl_f)
  );

  pin_filter u_sda_filt (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .pin_i    (SDA_I),
    .level_o  (sda_f)
  );

  // Register accesses cross into the register clock.
  reg_bridge u_bridge (
    .clk_i       (CLK_I),
    .arst_n_i    (ARST_N_I),
    .reg_clk_i   (REG_CLK_I),
    .req_i       (fetch_go | write_go),
    .req_write_i (write_go),
    .req_addr_i  (ptr_reg),
    .req_wdata_i (shift_reg),
    .done_o      (rd_done),
    .rdata_o     (rd_data),
    .reg_addr_o  (REG_ADDR_O),
    .reg_wdata_o (REG_WDATA_O),
    .reg_wr_o    (REG_WR_O),
    .reg_rd_o    (REG_RD_O),
    .reg_rdata_i (REG_RDATA_I)
  );

  // Address strap pins and previous line levels.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      al_s1_reg <= 2'h0;
      al_s2_reg <= 2'h0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      al_s1_reg <= ADDR_LOW_I;
      al_s2_reg <= al_s1_reg;
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  // Bus events from the filtered lines.
  assign scl_rise  = scl_f & ~scl_d_reg;
  assign scl_fall  = ~scl_f & scl_d_reg;
  assign start_evt = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  assign stop_evt  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;

  // Bit slots: acknowledge slot opens, acknowledge slot closes.
  assign byte_done = scl_fall & (bit_cnt_reg == BIT_CNT_BYTE);
  assign ack_end   = scl_fall & (bit_cnt_reg == BIT_CNT_ACK);
  assign rx_state  = (state_reg == ST_ADDR) | (state_reg == ST_PTR) |
                     (state_reg == ST_WDATA);

  // Address decode; reserved codes all fail the fixed upper bits.
  assign addr_hit = (shift_reg[7:3] == DEV_ADDR_FIXED) &
                    (shift_reg[2:1] == al_s2_reg);

  // Register traffic requests.
  assign addr_read_hit = byte_done & (state_reg == ST_ADDR) & addr_hit &
                         (shift_reg[0] == RW_READ);
  assign load_tx  = ack_end & ((state_reg == ST_RDATA) |
                    ((state_reg == ST_ADDR) & (shift_reg[0] == RW_READ)));
  assign write_go = byte_done & (state_reg == ST_WDATA);
  assign fetch_go = addr_read_hit | load_tx;
  assign nack_seen = scl_rise & (state_reg == ST_RDATA) &
                     (bit_cnt_reg == BIT_CNT_BYTE) & sda_f;

  // Pointer holds on the FIFO and steps everywhere else.
  assign ptr_adv = (ptr_reg == FIFO_ADDR) ? ptr_reg :
                   ptr_reg + PTR_STEP;

  // Frame sequencer.
  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    ptr_next     = ptr_reg;
    oe_n_next    = SDA_OE_N_O;
    sda_o_next   = SDA_O;
    busy_next    = BUSY_O;
    if (stop_evt) begin
      state_next   = ST_IDLE;
      bit_cnt_next = 4'h0;
      oe_n_next    = 1'b1;
      sda_o_next   = 1'b1;
      busy_next    = 1'b0;
    end else if (start_evt) begin
      state_next   = ST_ADDR;
      bit_cnt_next = 4'h0;
      oe_n_next    = 1'b1;
      sda_o_next   = 1'b1;
      busy_next    = 1'b1;
    end else if (rx_state) begin
      if (scl_rise && bit_cnt_reg < BIT_CNT_BYTE) begin
        shift_next   = {shift_reg[6:0], sda_f};
        bit_cnt_next = bit_cnt_reg + 4'h1;
      end else if (scl_rise) begin
        bit_cnt_next = BIT_CNT_ACK;
      end else if (byte_done) begin
        oe_n_next  = 1'b0;
        sda_o_next = 1'b0;
        if (state_reg == ST_ADDR && !addr_hit) begin
          state_next = ST_IGNORE;
          oe_n_next  = 1'b1;
          sda_o_next = 1'b1;
        end else if (state_reg == ST_PTR) begin
          ptr_next = shift_reg;
        end else if (addr_read_hit || write_go) begin
          ptr_next = ptr_adv;
        end
      end else if (ack_end) begin
        bit_cnt_next = 4'h0;
        oe_n_next    = 1'b1;
        sda_o_next   = 1'b1;
        if (load_tx) begin
          state_next = ST_RDATA;
          shift_next = {rd_data[6:0], 1'b0};
          sda_o_next = rd_data[7];
          oe_n_next  = rd_data[7];
          ptr_next   = ptr_adv;
        end else if (state_reg == ST_ADDR) begin
          state_next = ST_PTR;
        end else begin
          state_next = ST_WDATA;
        end
      end
    end else if (state_reg == ST_RDATA) begin
      if (nack_seen) begin
        state_next = ST_IGNORE;
      end else if (scl_rise) begin
        bit_cnt_next = bit_cnt_reg + 4'h1;
      end else if (byte_done) begin
        oe_n_next  = 1'b1;
        sda_o_next = 1'b1;
      end else if (load_tx) begin
        bit_cnt_next = 4'h0;
        shift_next   = {rd_data[6:0], 1'b0};
        sda_o_next   = rd_data[7];
        oe_n_next    = rd_data[7];
        ptr_next     = ptr_adv;
      end else if (scl_fall) begin
        shift_next = {shift_reg[6:0], 1'b0};
        sda_o_next = shift_reg[7];
        oe_n_next  = shift_reg[7];
      end
    end
  end

  // Sequencer state; the line is driven open-drain style.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= PTR_RESET;
      SDA_OE_N_O  <= 1'b1;
      SDA_O       <= 1'b1;
      BUSY_O      <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      ptr_reg     <= ptr_next;
      SDA_OE_N_O  <= oe_n_next;
      SDA_O       <= sda_o_next;
      BUSY_O      <= busy_next;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  // Named steps of an address byte.
  sequence s_addr_slot;
    (state_reg == ST_ADDR) && byte_done;
  endsequence

  sequence s_held_low;
    (!SDA_OE_N_O)[*4];
  endsequence

  // Start makes the bus busy and opens the address phase.
  a_start_busy:
  assert property (start_evt |=> BUSY_O && state_reg == ST_ADDR &&
                   bit_cnt_reg == 4'h0)
    else $error("start did not open address phase");

  // Repeated start keeps the bus busy and releases the line.
  a_restart_busy:
  assert property ((BUSY_O && start_evt) |=> BUSY_O && SDA_OE_N_O)
    else $error("repeated start mishandled");

  // Stop frees the bus.
  a_stop_free:
  assert property (stop_evt |=> !BUSY_O && state_reg == ST_IDLE)
    else $error("stop did not end the frame");

  // General call is never acknowledged.
  a_gcall_ignore:
  assert property ((s_addr_slot and (shift_reg[7:1] == GCALL_ADDR)) |=>
                   state_reg == ST_IGNORE && SDA_OE_N_O)
    else $error("general call was answered");

  // Device identification address is never acknowledged.
  a_devid_ignore:
  assert property ((s_addr_slot and (shift_reg[7:1] == DEVID_ADDR)) |=>
                   state_reg == ST_IGNORE && SDA_OE_N_O)
    else $error("device id request was answered");

  // High-speed master code is never acknowledged.
  a_hs_ignore:
  assert property ((s_addr_slot and (shift_reg[7:3] == HS_CODE_HI)) |=>
                   SDA_OE_N_O)
    else $error("high-speed code was acknowledged");

  // A matching address is acknowledged low for several cycles.
  a_addr_ack:
  assert property ((s_addr_slot and addr_hit) |=> s_held_low)
    else $error("matching address not acknowledged");

  // FIFO writes leave the pointer in place.
  a_ptr_fifo:
  assert property ((write_go && ptr_reg == FIFO_ADDR) |=>
                   $stable(ptr_reg))
    else $error("pointer moved on FIFO write");

  // Other writes step the pointer by one.
  a_ptr_step:
  assert property ((write_go && ptr_reg != FIFO_ADDR) |=>
                   ptr_reg == $past(ptr_reg) + PTR_STEP)
    else $error("pointer did not step after write");

  // After a not-acknowledge the line stays released.
  a_nack_release:
  assert property (nack_seen |=> (SDA_OE_N_O && state_reg == ST_IGNORE)
                   [*8])
    else $error("line not released after nack");

  // Every register fetch returns in bounded time.
  a_fetch_done:
  assert property (fetch_go |-> ##[1:RD_FETCH_MAX] rd_done)
    else $error("register fetch too slow");

  // The slave starts pulling only while the clock is low.
  a_drive_low:
  assert property ($fell(SDA_OE_N_O) |-> !scl_f)
    else $error("line driven while clock high");

  // The pointer byte loads the register pointer.
  a_ptr_load:
  assert property (((state_reg == ST_PTR) && byte_done) |=>
                   ptr_reg == $past(shift_reg))
    else $error("pointer byte not taken");

  // Reads at the FIFO keep the pointer in place.
  a_rd_fifo_hold:
  assert property ((load_tx && ptr_reg == FIFO_ADDR) |=> $stable(ptr_reg))
    else $error("pointer moved on FIFO read");

  // Reads elsewhere step the pointer by one.
  a_rd_step:
  assert property ((load_tx && ptr_reg != FIFO_ADDR) |=>
                   ptr_reg == $past(ptr_reg) + PTR_STEP)
    else $error("pointer did not step after read");

  // The transmitter lets go of the line for the master's acknowledge.
  a_tx_release:
  assert property (((state_reg == ST_RDATA) && byte_done) |=> SDA_OE_N_O)
    else $error("line held during master acknowledge");

  // Every data byte of a write frame is acknowledged low.
  a_wr_ack:
  assert property (((state_reg == ST_WDATA) && byte_done) |=> !SDA_OE_N_O)
    else $error("write data byte not acknowledged");

  // An ignored frame never pulls the line.
  a_ignore_quiet:
  assert property ((state_reg == ST_IGNORE) |-> SDA_OE_N_O)
    else $error("line driven while ignoring");

endmodule

// file: core/i2c_slave_pkg.sv
// Purpose: Shared constants and types for the two-wire register slave.
// Assumes: CLK_I runs at 125 MHz.
// Notes:   Timing figures are kept in their own units and derived here.
package i2c_slave_pkg;

  // System clock period and the spike width that the pin filter removes.
  localparam int CLK_PERIOD_NS = 8;
  localparam int SPIKE_NS      = 50;
  localparam int FILT_CYCLES   = (SPIKE_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam logic [2:0] FILT_LAST = 3'(FILT_CYCLES - 1);

  // Fastest supported bit rate and its bit period in system cycles.
  localparam int FAST_PLUS_KBPS  = 1000;
  localparam int BIT_NS_MIN      = 1000000 / FAST_PLUS_KBPS;
  localparam int BIT_CYCLES_MIN  = BIT_NS_MIN / CLK_PERIOD_NS;

  // Slave address: fixed upper part, reserved addresses never matched.
  localparam logic [4:0] DEV_ADDR_FIXED = 5'h0A;
  localparam logic [6:0] GCALL_ADDR     = 7'h00;
  localparam logic [6:0] DEVID_ADDR     = 7'h7C;
  localparam logic [4:0] HS_CODE_HI     = 5'h01;
  localparam logic       RW_READ        = 1'b1;

  // Bit counter values: byte complete, acknowledge sampled.
  localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_ACK  = 4'h9;

  // Register pointer reset value and default FIFO location.
  localparam logic [7:0] PTR_RESET         = 8'h00;
  localparam logic [7:0] PTR_STEP          = 8'h01;
  localparam logic [7:0] FIFO_ADDR_DEFAULT = 8'h0F;

  // Frame phases of the slave.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_IGNORE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA
  } state_type;

endpackage

// file: core/pin_filter.sv
// Purpose: Synchronise a bus pin and suppress short spikes on it.
// Assumes: The pin idles high.
// Notes:   The level follows only after FILT_CYCLES equal samples.
`timescale 1ns/1ps
module pin_filter (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);
  import i2c_slave_pkg::*;

  logic       s1_reg;
  logic       s2_reg;
  logic [2:0] cnt_reg;
  logic       differs;

  // Two-stage synchroniser; only the second stage is read.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
    end
  end

  assign differs = (s2_reg != level_o);

  // Spike suppression: a new level must persist before it is taken.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= 3'h0;
      level_o <= 1'b1;
    end else if (!differs) begin
      cnt_reg <= 3'h0;
    end else if (cnt_reg == FILT_LAST) begin
      cnt_reg <= 3'h0;
      level_o <= s2_reg;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

endmodule

// file: core/reg_bridge.sv
// Purpose: Carry register reads and writes into the register clock.
// Assumes: Read data is valid one reg clock after the read strobe.
// Notes:   Toggle handshake; a new request is taken at once, without waiting for the last done.
`timescale 1ns/1ps
module reg_bridge (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       reg_clk_i,
  input  wire logic       req_i,
  input  wire logic       req_write_i,
  input  wire logic [7:0] req_addr_i,
  input  wire logic [7:0] req_wdata_i,
  output logic            done_o,
  output logic [7:0]      rdata_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  logic       req_tgl_reg, write_hold_reg;
  logic [7:0] addr_hold_reg, wdata_hold_reg, rdata_hold_reg;
  logic       a1_reg, a2_reg, a3_reg;
  logic       r1_reg, r2_reg, r3_reg, pend_reg, ack_tgl_reg;
  logic       rst1_reg, rst2_reg;
  logic       req_seen, ack_seen;

  assign ack_seen = a2_reg ^ a3_reg;
  assign req_seen = r2_reg ^ r3_reg;

  // Request side: hold the words stable until the next request.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_tgl_reg    <= 1'b0;
      write_hold_reg <= 1'b0;
      addr_hold_reg  <= 8'h00;
      wdata_hold_reg <= 8'h00;
    end else if (req_i) begin
      req_tgl_reg    <= ~req_tgl_reg;
      write_hold_reg <= req_write_i;
      addr_hold_reg  <= req_addr_i;
      wdata_hold_reg <= req_wdata_i;
    end
  end

  // Answer side in the system clock: synchronise the acknowledge toggle.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a1_reg  <= 1'b0;
      a2_reg  <= 1'b0;
      a3_reg  <= 1'b0;
      done_o  <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      a1_reg <= ack_tgl_reg;
      a2_reg <= a1_reg;
      a3_reg <= a2_reg;
      done_o <= ack_seen;
      if (ack_seen) begin
        rdata_o <= rdata_hold_reg;
      end
    end
  end

  // Reset for the register clock: asserted at once, released clocked.
  always_ff @(posedge reg_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst1_reg <= 1'b0;
      rst2_reg <= 1'b0;
    end else begin
      rst1_reg <= 1'b1;
      rst2_reg <= rst1_reg;
    end
  end

  // Register clock side: strobe once per request, then return data.
  always_ff @(posedge reg_clk_i or negedge rst2_reg) begin
    if (!rst2_reg) begin
      r1_reg         <= 1'b0;
      r2_reg         <= 1'b0;
      r3_reg         <= 1'b0;
      pend_reg       <= 1'b0;
      ack_tgl_reg    <= 1'b0;
      reg_wr_o       <= 1'b0;
      reg_rd_o       <= 1'b0;
      reg_addr_o     <= 8'h00;
      reg_wdata_o    <= 8'h00;
      rdata_hold_reg <= 8'h00;
    end else begin
      r1_reg   <= req_tgl_reg;
      r2_reg   <= r1_reg;
      r3_reg   <= r2_reg;
      pend_reg <= req_seen;
      reg_wr_o <= req_seen & write_hold_reg;
      reg_rd_o <= req_seen & ~write_hold_reg;
      if (req_seen) begin
        reg_addr_o  <= addr_hold_reg;
        reg_wdata_o <= wdata_hold_reg;
      end
      if (pend_reg) begin
        rdata_hold_reg <= reg_rdata_i;
        ack_tgl_reg    <= ~ack_tgl_reg;
      end
    end
  end

endmodule

// file: test/i2c_host_model.sv
// Purpose: Behavioural two-wire bus master that drives the register slave.
// Assumes: SDA has a pull-up; the slave can only ever pull it low.
// Notes:   Bit time is 1 us; SCL stands high between frames.
`timescale 1ns/1ps
module i2c_host_model (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  // A quarter of the 1 us fast-plus bit period.
  localparam int QTR_NS = 250;

  // Both lines start idle high.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // One bit: SDA moves while SCL is low and is sampled mid-high.
  task automatic bit_io(input logic b, output logic s);
    #QTR_NS sda_o = b;
    #QTR_NS scl_o = 1'b1;
    #QTR_NS s = sda_i;
    #QTR_NS scl_o = 1'b0;
  endtask

  // Start, or repeated start when entered with SCL low.
  task automatic start_cond();
    #QTR_NS sda_o = 1'b1;
    #QTR_NS scl_o = 1'b1;
    #QTR_NS sda_o = 1'b0;
    #QTR_NS scl_o = 1'b0;
  endtask

  // Stop leaves both lines high.
  task automatic stop_cond();
    #QTR_NS sda_o = 1'b0;
    #QTR_NS scl_o = 1'b1;
    #QTR_NS sda_o = 1'b1;
    #QTR_NS;
  endtask

  // Sends a byte and releases SDA for the slave's acknowledge.
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack);
  endtask

  // Reads a byte; the last one is left unacknowledged.
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, s);
  endtask

  // A 20 ns SCL spike while SCL is low, shorter than the filter.
  task automatic spike_scl();
    #QTR_NS scl_o = 1'b1;
    #20 scl_o = 1'b0;
  endtask
endmodule

// file: test/test_i2c_slave_register_access.sv
// Purpose: Self-checking bench for the two-wire register slave.
// Assumes: The register file answers combinationally from its address.
// Notes:   Register contents are preset to address XOR 8'h5A.
`timescale 1ns/1ps
module test_i2c_slave_register_access;
  import i2c_slave_pkg::*;
  localparam int TIMEOUT_CYCLES = 60000;
  logic        clk;
  logic        reg_clk;
  logic        arst_n;
  logic        scl;
  logic        host_sda;
  logic        sda_w;
  logic        sda_out;
  logic        sda_oe_n;
  logic [1:0]  addr_low;
  logic [6:0]  dev_addr;
  logic        busy;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [7:0]  mem [256];
  logic [15:0] wq [$];
  logic [7:0]  rq [$];
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  // Open-drain wire with pull-up; own address follows the low bits.
  assign sda_w     = sda_oe_n & host_sda;
  assign dev_addr  = {DEV_ADDR_FIXED, addr_low};
  assign reg_rdata = mem[reg_addr];

  i2c_slave_register_access #(.FIFO_ADDR(FIFO_ADDR_DEFAULT))
    i2c_slave_register_access_inst (
    .CLK_I(clk), .ARST_N_I(arst_n), .REG_CLK_I(reg_clk), .SCL_I(scl),
    .SDA_I(sda_w), .SDA_O(sda_out), .SDA_OE_N_O(sda_oe_n),
    .ADDR_LOW_I(addr_low), .BUSY_O(busy), .REG_ADDR_O(reg_addr),
    .REG_WDATA_O(reg_wdata), .REG_WR_O(reg_wr), .REG_RD_O(reg_rd),
    .REG_RDATA_I(reg_rdata));

  i2c_host_model i2c_host_model_inst (
    .scl_o(scl), .sda_o(host_sda), .sda_i(sda_w));

  // System clock at 8 ns and an unrelated 125 ns register clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    reg_clk = 1'b0;
    #37;
    forever #62.5 reg_clk = ~reg_clk;
  end

  // Register file logs every write and every read address.
  always @(posedge reg_clk) begin
    if (reg_wr === 1'b1) wq.push_back({reg_addr, reg_wdata});
    if (reg_rd === 1'b1) rq.push_back(reg_addr);
  end

  // The slave may only move SDA while SCL is low.
  always @(sda_oe_n) begin
    if (arst_n === 1'b1) check("sda_move_scl", 16'(scl), 16'h0000);
  end

  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES) begin
      num_errors++;
      results();
    end
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Write frame of pointer and three data bytes, all acknowledged.
  task automatic send_write(input logic [7:0] ptr, input logic [7:0] base,
                            input logic spike);
    logic ack;
    wq.delete();
    i2c_host_model_inst.start_cond();
    check("busy_start", 16'(busy), 16'h0001);
    i2c_host_model_inst.write_byte({dev_addr, 1'b0}, ack);
    check("ack_addr", 16'(ack), 16'h0000);
    i2c_host_model_inst.write_byte(ptr, ack);
    check("ack_ptr", 16'(ack), 16'h0000);
    if (spike) i2c_host_model_inst.spike_scl();
    for (int i = 0; i < 3; i++) begin
      i2c_host_model_inst.write_byte(base + 8'(i), ack);
      check("ack_data", 16'(ack), 16'h0000);
    end
    i2c_host_model_inst.stop_cond();
    check("busy_stop", 16'(busy), 16'h0000);
    for (int k = 0; k < 16 && wq.size() < 3; k++) @(posedge reg_clk);
    check("wr_count", 16'(wq.size()), 16'h0003);
  endtask

  // Pointer setup, repeated start, three reads ending in not-ack.
  task automatic send_read(input logic [7:0] ptr, output logic [23:0] got);
    logic ack;
    rq.delete();
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.write_byte({dev_addr, 1'b0}, ack);
    i2c_host_model_inst.write_byte(ptr, ack);
    check("ack_rptr", 16'(ack), 16'h0000);
    i2c_host_model_inst.start_cond();
    check("busy_rstart", 16'(busy), 16'h0001);
    i2c_host_model_inst.write_byte({dev_addr, RW_READ}, ack);
    check("ack_raddr", 16'(ack), 16'h0000);
    for (int i = 2; i >= 0; i--) begin
      i2c_host_model_inst.read_byte(i == 0, got[i*8 +: 8]);
    end
    check("release_nack", 16'(sda_oe_n), 16'h0001);
    check("release_sda", 16'(sda_out), 16'h0001);
    i2c_host_model_inst.stop_cond();
  endtask

  task automatic test_write();
    send_write(8'h10, 8'hA5, 1'b1);
    for (int i = 0; i < 3; i++) begin
      check("wr_seq", wq[i], {8'h10 + 8'(i), 8'hA5 + 8'(i)});
    end
    $display("test_write done");
  endtask

  task automatic test_fifo_write();
    send_write(FIFO_ADDR_DEFAULT, 8'h3C, 1'b0);
    for (int i = 0; i < 3; i++) begin
      check("wr_fifo", wq[i], {FIFO_ADDR_DEFAULT, 8'h3C + 8'(i)});
    end
    $display("test_fifo_write done");
  endtask

  task automatic test_read();
    logic [23:0] got;
    send_read(8'h20, got);
    for (int i = 0; i < 3; i++) begin
      check("rd_data", 16'(got[23-8*i -: 8]),
            16'((8'h20 + 8'(i)) ^ 8'h5A));
    end
    check("rd_first", 16'(rq[0]), 16'h0020);
    $display("test_read done");
  endtask

  task automatic test_fifo_read();
    logic [23:0] got;
    send_read(FIFO_ADDR_DEFAULT, got);
    for (int i = 0; i < 3; i++) begin
      check("rd_fifo", 16'(got[8*i +: 8]),
            16'(FIFO_ADDR_DEFAULT ^ 8'h5A));
    end
    check("rd_fetches", 16'(rq.size()), 16'h0004);
    foreach (rq[i]) begin
      check("rd_ptr", 16'(rq[i]), 16'(FIFO_ADDR_DEFAULT));
    end
    $display("test_fifo_read done");
  endtask

  // Foreign, reserved and wrong-low-bit addresses are never acked.
  task automatic test_reject();
    logic [6:0] bad [6];
    logic       ack;
    bad = '{{DEV_ADDR_FIXED, 2'b01}, {DEV_ADDR_FIXED, 2'b11}, 7'h6A,
            GCALL_ADDR, DEVID_ADDR, {HS_CODE_HI, 2'b10}};
    @(posedge clk);
    #1 addr_low = 2'b10;
    wq.delete();
    foreach (bad[i]) begin
      i2c_host_model_inst.start_cond();
      i2c_host_model_inst.write_byte({bad[i], 1'b0}, ack);
      check("nack_addr", 16'(ack), 16'h0001);
      i2c_host_model_inst.write_byte(8'h77, ack);
      check("nack_after", 16'(ack), 16'h0001);
      i2c_host_model_inst.stop_cond();
    end
    check("no_write", 16'(wq.size()), 16'h0000);
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.write_byte({dev_addr, 1'b0}, ack);
    check("ack_low10", 16'(ack), 16'h0000);
    i2c_host_model_inst.stop_cond();
    $display("test_reject done");
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset spans both clock domains, then the scenarios run in turn.
  initial begin
    arst_n   = 1'b0;
    addr_low = 2'b01;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    repeat (5) @(posedge reg_clk);
    @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (20) @(posedge clk);
    check("idle_oe_n", 16'(sda_oe_n), 16'h0001);
    check("idle_busy", 16'(busy), 16'h0000);
    test_write();
    test_fifo_write();
    test_read();
    test_fifo_read();
    test_reject();
    results();
  end
endmodule
